// File: hdl/feature_pkg.sv
/*
  Shared constants and types for the feature subcommand handler.
  Assumes a single device clock and that all command inputs are on that clock.
*/
package feature_pkg;
  // ****************************************
  // Feature codes
  // ****************************************
  localparam logic [7:0] FEAT_WC_ON = 8'h02;
  localparam logic [7:0] FEAT_XFER_MODE = 8'h03;
  localparam logic [7:0] FEAT_APM_ON = 8'h05;
  localparam logic [7:0] FEAT_PUIS_ON = 8'h06;
  localparam logic [7:0] FEAT_PUIS_SPIN = 8'h07;
  localparam logic [7:0] FEAT_SATA_ON = 8'h10;
  localparam logic [7:0] FEAT_SECTOR_TIME = 8'h43;
  localparam logic [7:0] FEAT_EPC = 8'h4a;
  localparam logic [7:0] FEAT_RLA_OFF = 8'h55;
  localparam logic [7:0] FEAT_REVERT_OFF = 8'h66;
  localparam logic [7:0] FEAT_WC_OFF = 8'h82;
  localparam logic [7:0] FEAT_APM_OFF = 8'h85;
  localparam logic [7:0] FEAT_PUIS_OFF = 8'h86;
  localparam logic [7:0] FEAT_SATA_OFF = 8'h90;
  localparam logic [7:0] FEAT_RLA_ON = 8'haa;
  localparam logic [7:0] FEAT_REVERT_ON = 8'hcc;
  // ****************************************
  // Serial link feature selectors
  // ****************************************
  localparam logic [7:0] SATA_BUF_OFFSET = 8'h01;
  localparam logic [7:0] SATA_AUTO_ACT = 8'h02;
  localparam logic [7:0] SATA_DIPM = 8'h03;
  localparam logic [7:0] SATA_IN_ORDER = 8'h04;
  localparam logic [7:0] SATA_PRESERVE = 8'h06;
  localparam logic [4:0] SATA_FEAT_RESET = 5'h00;
  // ****************************************
  // Power saving level decode
  // ****************************************
  localparam logic [7:0] LVL_ABORT_HI = 8'hff;
  localparam logic [7:0] LVL_ABORT_LO = 8'h00;
  localparam logic [7:0] LVL_NORMAL_MIN = 8'hc0;
  localparam logic [7:0] LVL_LOW_POWER_MIN = 8'h80;
  localparam logic [7:0] LVL_RS_SCALE_MIN = 8'h40;
  localparam logic [8:0] LP_STEP_S = 9'h005;
  localparam logic [8:0] LP_IDLE_DEFAULT_S = 9'h078;
  localparam logic [12:0] RS_STEP_S = 13'h003c;
  localparam logic [12:0] RS_FIXED_S = 13'h0258;
  localparam logic [7:0] LEVEL_RESET = 8'hfe;
  // ****************************************
  // Register fields and restore subcommand
  // ****************************************
  localparam int ERR_ABORT_BIT = 2;
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_READY_BIT = 6;
  localparam int ST_FAULT_BIT = 5;
  localparam int ST_ERR_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h40;
  localparam logic [7:0] ERROR_RESET = 8'h00;
  localparam int SN_DEFAULT_BIT = 6;
  localparam int SN_SAVE_BIT = 4;
  localparam logic [3:0] EPC_SUB_RESTORE = 4'h0;
  localparam logic [15:0] EPC_DEFAULT_TIMER = 16'h0000;
  localparam logic EPC_DEFAULT_ENABLE = 1'b0;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {APM_NORMAL = 2'h0, APM_LOW_POWER = 2'h1, APM_REDUCED_SPEED = 2'h3} apm_mode_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} cmd_state_t;
endpackage : feature_pkg

// File: hdl/apm_if.sv
/*
  Carrier between the handler and its power saving level decoder.
  Assumes both ends sit on the same clock; signals are combinational.
*/
interface apm_if;
  import feature_pkg::*;
  logic [7:0] level;
  logic legal;
  apm_mode_t mode;
  logic [8:0] lp_time;
  logic [12:0] rs_time;
  modport decoder (input level, output legal, output mode, output lp_time, output rs_time);
  modport user (output level, input legal, input mode, input lp_time, input rs_time);
endinterface : apm_if

// File: hdl/apm_level_decode.sv
/*
  Power saving level decoder: deepest mode and idle times in seconds.
  Assumes the level is held stable by the user while it is read.
*/
module apm_level_decode
  import feature_pkg::*;
(
  // Level in, decode out
  apm_if.decoder a
);
  // ****************************************
  // Decode
  // ****************************************
  // Pure logic; the handler registers whatever it keeps
  always_comb begin
    a.legal = (a.level != LVL_ABORT_HI) && (a.level != LVL_ABORT_LO);
    a.lp_time = LP_IDLE_DEFAULT_S;
    a.rs_time = RS_FIXED_S;
    if (a.level >= LVL_NORMAL_MIN) begin
      a.mode = APM_NORMAL;
    end else if (a.level >= LVL_LOW_POWER_MIN) begin
      a.mode = APM_LOW_POWER;
      a.lp_time = 9'(a.level - LVL_LOW_POWER_MIN) * LP_STEP_S + LP_IDLE_DEFAULT_S;
      a.rs_time = 13'h0000;
    end else begin
      a.mode = APM_REDUCED_SPEED;
      if (a.level >= LVL_RS_SCALE_MIN) begin
        a.rs_time = 13'(a.level - LVL_RS_SCALE_MIN) * RS_STEP_S + RS_FIXED_S;
      end
    end
  end
endmodule : apm_level_decode

// File: hdl/feature_subcommand_handler.sv
/*
  Set-features subcommand handler: write cache, serial link features, power saving
  level, host sector time hint and power condition restore.
  Assumes the command block inputs are driven by logic on clk and held only for the
  cycle of cmd_valid; a new command is ignored while one is executing.
*/
module feature_subcommand_handler
  import feature_pkg::*;
#(
  parameter int NUM_COND = 2,
  parameter logic [15:0] DEFAULT_TIMER = EPC_DEFAULT_TIMER,
  parameter logic DEFAULT_ENABLE = EPC_DEFAULT_ENABLE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Reset requests from the link layer
  input wire logic hard_reset,
  input wire logic soft_reset,
  // Command block
  input wire logic cmd_valid,
  input wire logic [7:0] feature,
  input wire logic [7:0] sector_count,
  input wire logic [7:0] sector_number,
  input wire logic [7:0] lba_low,
  input wire logic [7:0] lba_mid,
  input wire logic [7:0] lba_high,
  // Media and power condition context
  input wire logic [15:0] reassign_count,
  input wire logic [15:0] reassign_capacity,
  input wire logic extended_power_conditions,
  input wire logic [NUM_COND-1:0] cond_supported,
  input wire logic [NUM_COND-1:0] cond_changeable,
  input wire logic [NUM_COND-1:0] cond_saveable,
  // Completion
  output logic [7:0] command_error_flags,
  output logic [7:0] command_status_flags,
  output logic cmd_done,
  // Feature state
  output logic write_cache_en,
  output logic [4:0] sata_feature_en,
  output apm_mode_t apm_mode,
  output logic [8:0] low_power_idle_time,
  output logic [12:0] reduced_speed_idle_time,
  output logic [15:0] dma_sector_time,
  output logic [7:0] pio_sector_time_hi,
  output logic host_full_rate,
  output logic [NUM_COND*16-1:0] current_timer,
  output logic [NUM_COND-1:0] current_enable,
  output logic [NUM_COND*16-1:0] saved_timer,
  output logic [NUM_COND-1:0] saved_enable
);
  // ****************************************
  // Declarations
  // ****************************************
  cmd_state_t state_r;
  logic [7:0] feat_r, sc_r, sn_r, lo_r, mid_r, hi_r;
  logic [7:0] err_r, stat_r;
  logic done_r, wc_en_r, wc_locked_r, revert_en_r;
  logic [4:0] sata_r, sata_sel;
  apm_mode_t mode_r;
  logic [8:0] lp_time_r;
  logic lp_set_r;
  logic [12:0] rs_time_r;
  logic [15:0] dma_time_r;
  logic [7:0] pio_hi_r;
  logic full_rate_r;
  logic [15:0] cur_t_r [NUM_COND];
  logic [15:0] sav_t_r [NUM_COND];
  logic [NUM_COND-1:0] cur_e_r, sav_e_r;
  logic abort_nxt, restore_ok, exec, apm_reinit;
  logic [$clog2(NUM_COND)-1:0] cidx;
  logic id_ok;
  apm_if a ();

  apm_level_decode u_decode (
    .a(a)
  );

  assign a.level = sc_r;
  assign exec = (state_r == ST_EXEC);
  assign cidx = sc_r[$clog2(NUM_COND)-1:0];
  assign id_ok = 32'(sc_r) < NUM_COND;
  // Soft reset keeps power saving while reverting to defaults is disabled
  assign apm_reinit = hard_reset || (soft_reset && revert_en_r);

  // ****************************************
  // Command sequencing and completion status
  // ****************************************
  // Accept one command, execute it the next cycle, report on the one after
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      feat_r <= 8'h00;
      sc_r <= 8'h00;
      sn_r <= 8'h00;
      lo_r <= 8'h00;
      mid_r <= 8'h00;
      hi_r <= 8'h00;
      stat_r <= STATUS_RESET;
      err_r <= ERROR_RESET;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (cmd_valid) begin
            state_r <= ST_EXEC;
            feat_r <= feature;
            sc_r <= sector_count;
            sn_r <= sector_number;
            lo_r <= lba_low;
            mid_r <= lba_mid;
            hi_r <= lba_high;
            stat_r[ST_BUSY_BIT] <= 1'b1;
          end
        end
        ST_EXEC: begin
          state_r <= ST_IDLE;
          done_r <= 1'b1;
          stat_r <= STATUS_RESET;
          stat_r[ST_BUSY_BIT] <= 1'b0;
          stat_r[ST_FAULT_BIT] <= 1'b0;
          stat_r[ST_ERR_BIT] <= abort_nxt;
          err_r <= ERROR_RESET;
          err_r[ERR_ABORT_BIT] <= abort_nxt;
        end
      endcase
    end
  end

  // ****************************************
  // Feature decode and abort checks
  // ****************************************
  // Accepted but inert codes belong to blocks outside this one
  always_comb begin
    abort_nxt = 1'b0;
    sata_sel = 5'h00;
    restore_ok = 1'b0;
    unique case (feat_r)
      FEAT_WC_ON, FEAT_WC_OFF, FEAT_XFER_MODE, FEAT_PUIS_ON, FEAT_PUIS_SPIN, FEAT_RLA_OFF,
      FEAT_REVERT_OFF, FEAT_APM_OFF, FEAT_PUIS_OFF, FEAT_RLA_ON, FEAT_REVERT_ON, FEAT_SECTOR_TIME: begin
        abort_nxt = 1'b0;
      end
      FEAT_APM_ON: begin
        abort_nxt = !a.legal;
      end
      FEAT_SATA_ON, FEAT_SATA_OFF: begin
        unique case (sc_r)
          SATA_BUF_OFFSET: sata_sel = 5'h01;
          SATA_AUTO_ACT: sata_sel = 5'h02;
          SATA_DIPM: sata_sel = 5'h04;
          SATA_IN_ORDER: sata_sel = 5'h08;
          SATA_PRESERVE: sata_sel = 5'h10;
          default: abort_nxt = 1'b1;
        endcase
      end
      FEAT_EPC: begin
        // Only restore lives here; other subcommands are refused
        abort_nxt = (sn_r[3:0] != EPC_SUB_RESTORE) || !extended_power_conditions || !id_ok;
        if (!abort_nxt) begin
          abort_nxt = !cond_supported[cidx] || !cond_changeable[cidx] ||
                      (sn_r[SN_SAVE_BIT] && !cond_saveable[cidx]);
        end
        restore_ok = !abort_nxt;
      end
      default: abort_nxt = 1'b1;
    endcase
  end

  // ****************************************
  // Write cache and reverting control
  // ****************************************
  // Lock is sticky until power-on reset; the media cannot take back reassignments
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wc_locked_r <= 1'b0;
      wc_en_r <= 1'b1;
      revert_en_r <= 1'b0;
    end else begin
      if (reassign_count >= reassign_capacity) begin
        wc_locked_r <= 1'b1;
      end
      if (wc_locked_r || (reassign_count >= reassign_capacity)) begin
        wc_en_r <= 1'b0;
      end else if (exec && feat_r == FEAT_WC_ON) begin
        wc_en_r <= 1'b1;
      end else if (exec && feat_r == FEAT_WC_OFF) begin
        wc_en_r <= 1'b0;
      end
      if (exec && feat_r == FEAT_REVERT_ON) begin
        revert_en_r <= 1'b1;
      end else if (exec && feat_r == FEAT_REVERT_OFF) begin
        revert_en_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Serial link features
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sata_r <= SATA_FEAT_RESET;
    end else if (exec && feat_r == FEAT_SATA_ON) begin
      sata_r <= sata_r | sata_sel;
    end else if (exec && feat_r == FEAT_SATA_OFF) begin
      sata_r <= sata_r & ~sata_sel;
    end
  end

  // ****************************************
  // Power saving level and idle times
  // ****************************************
  // Values only move on a legal level, a disable, or a reset request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= APM_NORMAL;
      lp_time_r <= 9'h000;
      lp_set_r <= 1'b0;
      rs_time_r <= 13'h0000;
    end else if (apm_reinit) begin
      mode_r <= APM_NORMAL;
      lp_time_r <= 9'h000;
      lp_set_r <= 1'b0;
      rs_time_r <= 13'h0000;
    end else if ((exec && feat_r == FEAT_APM_OFF) ||
                 (exec && feat_r == FEAT_APM_ON && a.legal && a.mode == APM_NORMAL)) begin
      mode_r <= APM_NORMAL;
      lp_time_r <= 9'h000;
      lp_set_r <= 1'b0;
      rs_time_r <= 13'h0000;
    end else if (exec && feat_r == FEAT_APM_ON && a.legal) begin
      mode_r <= a.mode;
      lp_set_r <= 1'b1;
      rs_time_r <= a.rs_time;
      if (a.mode == APM_LOW_POWER) begin
        lp_time_r <= a.lp_time;
      end else if (!lp_set_r) begin
        lp_time_r <= LP_IDLE_DEFAULT_S;
      end
    end
  end

  // ****************************************
  // Host interface sector time hint
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dma_time_r <= 16'h0000;
      pio_hi_r <= 8'h00;
      full_rate_r <= 1'b1;
    end else if (exec && feat_r == FEAT_SECTOR_TIME) begin
      dma_time_r <= {hi_r, mid_r};
      pio_hi_r <= lo_r;
      full_rate_r <= ({hi_r, mid_r, lo_r} == 24'h000000);
    end
  end

  // ****************************************
  // Power condition timer copies
  // ****************************************
  // One entry per condition; identifier is the entry index
  for (genvar i = 0; i < NUM_COND; i++) begin : g_cond
    logic hit;
    logic [15:0] new_t;
    assign hit = exec && restore_ok && (32'(cidx) == i);
    assign new_t = sn_r[SN_DEFAULT_BIT] ? DEFAULT_TIMER : sav_t_r[i];
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        cur_t_r[i] <= DEFAULT_TIMER;
        cur_e_r[i] <= DEFAULT_ENABLE;
        sav_t_r[i] <= DEFAULT_TIMER;
        sav_e_r[i] <= DEFAULT_ENABLE;
      end else if (hit) begin
        if (sn_r[SN_DEFAULT_BIT]) begin
          cur_t_r[i] <= DEFAULT_TIMER;
          cur_e_r[i] <= DEFAULT_ENABLE;
        end else begin
          cur_t_r[i] <= sav_t_r[i];
          cur_e_r[i] <= sav_e_r[i];
        end
        if (sn_r[SN_SAVE_BIT] && cond_saveable[i]) begin
          sav_t_r[i] <= new_t;
        end
      end
    end
    assign current_timer[i*16 +: 16] = cur_t_r[i];
    assign saved_timer[i*16 +: 16] = sav_t_r[i];
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign command_error_flags = err_r;
  assign command_status_flags = stat_r;
  assign cmd_done = done_r;
  assign write_cache_en = wc_en_r;
  assign sata_feature_en = sata_r;
  assign apm_mode = mode_r;
  assign low_power_idle_time = lp_time_r;
  assign reduced_speed_idle_time = rs_time_r;
  assign dma_sector_time = dma_time_r;
  assign pio_sector_time_hi = pio_hi_r;
  assign host_full_rate = full_rate_r;
  assign current_enable = cur_e_r;
  assign saved_enable = sav_e_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence accept_s;
    state_r == ST_IDLE && cmd_valid;
  endsequence
  sequence run_s(logic [7:0] f, logic [7:0] s);
    exec && feat_r == f && sc_r == s && !apm_reinit;
  endsequence

  busy_done_a: assert property (accept_s ##1 stat_r[ST_BUSY_BIT] |=> !stat_r[ST_BUSY_BIT] && done_r)
    else $error("busy not released with done");
  err_pair_a: assert property (done_r |-> stat_r[ST_ERR_BIT] == err_r[ERR_ABORT_BIT] && !stat_r[ST_FAULT_BIT])
    else $error("error status and abort disagree");
  wc_lock_a: assert property ($rose(wc_locked_r) |-> !wc_en_r ##1 !wc_en_r [*8])
    else $error("write cache on after lock");
  wc_quiet_a: assert property (exec && feat_r == FEAT_WC_ON && wc_locked_r |=> !err_r[ERR_ABORT_BIT] && !wc_en_r)
    else $error("locked cache enable misbehaved");
  sata_set_a: assert property (run_s(FEAT_SATA_ON, SATA_DIPM) |=> sata_r[2] && !err_r[ERR_ABORT_BIT])
    else $error("serial feature not enabled");
  apm_abort_a: assert property (run_s(FEAT_APM_ON, LVL_ABORT_LO) |=> err_r[ERR_ABORT_BIT] && $stable(mode_r))
    else $error("zero level not aborted");
  lp_time_a: assert property (run_s(FEAT_APM_ON, 8'h90) |=> mode_r == APM_LOW_POWER && lp_time_r == 9'h0c8)
    else $error("low power idle time wrong");
  rs_time_a: assert property (run_s(FEAT_APM_ON, 8'h7f) |=> rs_time_r == 13'h111c)
    else $error("reduced speed idle time wrong");
  rs_keep_a: assert property (run_s(FEAT_APM_ON, 8'h3f) && lp_set_r |=> rs_time_r == 13'h0258 && $stable(lp_time_r))
    else $error("reduced speed entry lost idle time");
  apm_off_a: assert property (exec && feat_r == FEAT_APM_OFF && !apm_reinit |=> mode_r == APM_NORMAL)
    else $error("power saving not disabled");
  undef_a: assert property (exec && feat_r == 8'h01 |=> err_r[ERR_ABORT_BIT] && stat_r[ST_ERR_BIT])
    else $error("undefined code not aborted");
  restore_a: assert property (exec && restore_ok && sn_r[SN_DEFAULT_BIT] |=> cur_t_r[cidx] == DEFAULT_TIMER)
    else $error("default timer not restored");
endmodule : feature_subcommand_handler

// File: tb/host_model.sv
/*
  Host controller model: issues one command block request per call.
  Assumes the device takes a request at the edge where cmd_valid is high.
*/
module host_model (
  // Clock
  input wire logic clk,
  // Command block
  output logic cmd_valid,
  output logic [7:0] feature,
  output logic [7:0] sector_count,
  output logic [7:0] sector_number,
  output logic [7:0] lba_low,
  output logic [7:0] lba_mid,
  output logic [7:0] lba_high
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Request driver
  // ****
  initial begin
    cmd_valid = 1'b0;
    {feature, sector_count, sector_number, lba_low, lba_mid, lba_high} = '0;
  end
  // Lines invert once taken, so stale values never pass for held ones
  task automatic send(input logic [47:0] cb);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    {feature, sector_count, sector_number, lba_low, lba_mid, lba_high} = cb;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    {feature, sector_count, sector_number, lba_low, lba_mid, lba_high} = ~cb;
  endtask : send
endmodule : host_model

// File: tb/feature_subcommand_handler_tb.sv
/*
  Self-checking bench for the feature subcommand handler with a reference model.
  Assumes the host model and the handler share one 200 MHz clock.
*/
module feature_subcommand_handler_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // Non-zero default so restore copies are visible
  localparam logic [15:0] DEF_T = 16'h1234;
  logic clk, nrst, hard_reset, soft_reset, cmd_valid, extended_power_conditions, cmd_done;
  logic write_cache_en, host_full_rate;
  logic [7:0] feature, sector_count, sector_number, lba_low, lba_mid, lba_high, pio_sector_time_hi;
  logic [7:0] command_error_flags, command_status_flags;
  logic [15:0] reassign_count, reassign_capacity, dma_sector_time;
  logic [1:0] cond_supported, cond_changeable, cond_saveable, current_enable, saved_enable;
  logic [4:0] sata_feature_en;
  feature_pkg::apm_mode_t apm_mode;
  logic [8:0] low_power_idle_time;
  logic [12:0] reduced_speed_idle_time;
  logic [31:0] current_timer, saved_timer;
  int mismatches, checks, m_mode, m_lp, m_rs, m_lps, m_rev, m_wce, m_lock, m_sata, m_dma, m_pio, m_full;
  int m_cur[2], m_sav[2], m_ce[2], m_se[2];
  logic [7:0] lv [11] = '{8'h90, 8'h3f, 8'h7f, 8'h40, 8'hbf, 8'h80, 8'hc0, 8'h01, 8'hfe, 8'h00, 8'hff};
  // Codes taken without effect here; they must still complete cleanly
  logic [7:0] inert [6] = '{8'h03, 8'h06, 8'h07, 8'h55, 8'h86, 8'haa};

  host_model host (.clk, .cmd_valid, .feature, .sector_count, .sector_number, .lba_low, .lba_mid, .lba_high);
  feature_subcommand_handler #(.DEFAULT_TIMER(DEF_T), .DEFAULT_ENABLE(1'b1)) dut (
    .clk, .nrst, .hard_reset, .soft_reset, .cmd_valid, .feature, .sector_count, .sector_number, .lba_low,
    .lba_mid, .lba_high, .reassign_count, .reassign_capacity, .extended_power_conditions, .cond_supported,
    .cond_changeable, .cond_saveable, .command_error_flags, .command_status_flags, .cmd_done, .write_cache_en,
    .sata_feature_en, .apm_mode, .low_power_idle_time, .reduced_speed_idle_time, .dma_sector_time,
    .pio_sector_time_hi, .host_full_rate, .current_timer, .current_enable, .saved_timer, .saved_enable);

  // 5 ns clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ****
  // Checking and model
  // ****
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // Normal idle clears both times and forgets the low-power time
  task automatic apm_init;
    m_mode = 0;
    m_lp = 0;
    m_rs = 0;
    m_lps = 0;
  endtask : apm_init
  task automatic lvl(input int x);
    if (x >= 'hc0) apm_init();
    else if (x >= 'h80) begin
      m_mode = 1;
      m_lp = (x - 'h80) * 5 + 120;
      m_rs = 0;
      m_lps = 1;
    end else begin
      m_mode = 3;
      m_lp = m_lps ? m_lp : 120;
      m_lps = 1;
      m_rs = x >= 'h40 ? (x - 'h40) * 60 + 600 : 600;
    end
  endtask : lvl
  task automatic state;
    chk("wce", write_cache_en, m_wce);
    chk("sata", sata_feature_en, m_sata);
    chk("mode", apm_mode, m_mode);
    chk("lp", low_power_idle_time, m_lp);
    chk("rs", reduced_speed_idle_time, m_rs);
    chk("dma", dma_sector_time, m_dma);
    chk("pio", pio_sector_time_hi, m_pio);
    chk("full", host_full_rate, m_full);
    for (int i = 0; i < 2; i++) begin
      chk("cur_t", current_timer[i*16+:16], m_cur[i]);
      chk("cur_e", current_enable[i], m_ce[i]);
      chk("sav_t", saved_timer[i*16+:16], m_sav[i]);
      chk("sav_e", saved_enable[i], m_se[i]);
    end
  endtask : state
  // Model first, then the request, then the bounded wait for completion
  task automatic feat(input logic [47:0] cb);
    logic [7:0] f, sc, sn;
    int ab, n, id;
    {f, sc, sn} = cb[47:24];
    ab = 0;
    id = sc;
    case (f)
      8'h05: if (sc == 8'h00 || sc == 8'hff) ab = 1; else lvl(sc);
      8'h85: apm_init();
      8'h10, 8'h90: begin
        n = sc == 1 ? 0 : sc == 2 ? 1 : sc == 3 ? 2 : sc == 4 ? 3 : sc == 6 ? 4 : 5;
        if (n == 5) ab = 1;
        else if (f == 8'h10) m_sata |= 1 << n;
        else m_sata &= ~(1 << n);
      end
      8'h43: begin
        m_dma = {cb[7:0], cb[15:8]};
        m_pio = cb[23:16];
        m_full = cb[23:0] == 0;
      end
      8'h02: m_wce = !m_lock;
      8'h82: m_wce = 0;
      8'h66: m_rev = 0;
      8'hcc: m_rev = 1;
      8'h03, 8'h06, 8'h07, 8'h55, 8'h86, 8'haa: ;
      8'h4a: begin
        if (sn[3:0] != 0 || !extended_power_conditions || id > 1 || !cond_supported[id] ||
            !cond_changeable[id] || (sn[4] && !cond_saveable[id])) ab = 1;
        else begin
          m_cur[id] = sn[6] ? DEF_T : m_sav[id];
          m_ce[id] = sn[6] ? 1 : m_se[id];
          if (sn[4]) m_sav[id] = m_cur[id];
        end
      end
      default: ab = 1;
    endcase
    host.send(cb);
    chk("busy", command_status_flags[7], 1'b1);
    n = 0;
    while (cmd_done !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (cmd_done !== 1'b1) begin
      mismatches++;
      results();
    end
    chk("error", command_error_flags, ab ? 8'h04 : 8'h00);
    chk("status", command_status_flags, ab ? 8'h41 : 8'h40);
    state();
    // Done stands for one cycle only
    @(posedge clk);
    #1;
    chk("done", cmd_done, 1'b0);
  endtask : feat
  task automatic pulse(input bit hard);
    @(posedge clk);
    #1;
    hard_reset = hard;
    soft_reset = !hard;
    @(posedge clk);
    #1;
    hard_reset = 1'b0;
    soft_reset = 1'b0;
    if (hard || m_rev) apm_init();
    state();
  endtask : pulse
  // ****
  // Main sequence
  // ****
  initial begin
    logic [31:0] r;
    {nrst, hard_reset, soft_reset, reassign_count} = '0;
    reassign_capacity = 16'h0100;
    extended_power_conditions = 1'b1;
    {cond_supported, cond_changeable, cond_saveable} = '1;
    {m_mode, m_lp, m_rs, m_lps, m_rev, m_lock, m_sata, m_dma, m_pio} = '0;
    {m_wce, m_full} = {32'd1, 32'd1};
    m_cur = '{DEF_T, DEF_T};
    m_sav = '{DEF_T, DEF_T};
    m_ce = '{1, 1};
    m_se = '{1, 1};
    void'($urandom(97457));
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    state();
    foreach (lv[i]) feat({8'h05, lv[i], 32'h0});
    repeat (4) feat({8'h05, 8'(1 + $urandom % 254), 32'h0});
    feat({8'h85, 40'h0});
    $display("power saving test done");
    foreach (lv[i]) if (i < 7) feat({i[0] ? 8'h90 : 8'h10, 8'(i == 6 ? 5 : i == 5 ? 6 : i), 32'h0});
    for (int i = 1; i < 7; i++) feat({8'h10, 8'(i), 32'h0});
    $display("serial feature test done");
    repeat (3) feat({8'h43, 16'h0, 24'($urandom)});
    feat({8'h43, 40'h0});
    foreach (lv[i]) if (i < 8) feat({8'(lv[i] ^ 8'h91), 40'h0});
    foreach (inert[i]) feat({inert[i], 40'h0});
    $display("sector time and code test done");
    feat({8'h05, 8'h90, 32'h0});
    feat({8'hcc, 40'h0});
    pulse(1'b0);
    feat({8'h66, 40'h0});
    feat({8'h05, 8'ha0, 32'h0});
    pulse(1'b0);
    pulse(1'b1);
    $display("reset test done");
    repeat (12) begin
      r = $urandom;
      extended_power_conditions = r[0] | r[1];
      cond_supported = r[3:2] | {2{r[4]}};
      cond_changeable = r[6:5] | {2{r[7]}};
      cond_saveable = r[9:8] | {2{r[10]}};
      feat({8'h4a, 6'h0, r[21:20], 1'b0, r[22], 1'b0, r[23], 3'h0, r[24] & r[25], 24'h0});
    end
    $display("restore test done");
    feat({8'h82, 40'h0});
    feat({8'h02, 40'h0});
    reassign_count = reassign_capacity;
    m_lock = 1;
    m_wce = 0;
    @(posedge clk);
    #1;
    state();
    feat({8'h02, 40'h0});
    $display("write cache test done");
    results();
  end
endmodule : feature_subcommand_handler_tb
